/* hub_wake_params.svh */
// Constants of the hub global-resume and wake logic
`ifndef HUB_WAKE_PARAMS_SVH
`define HUB_WAKE_PARAMS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_FREQ_KHZ 10000
`define WAKE_DELAY_US 1000
`define HW_K_DRIVE_US 2000
`define CNT_W 24
`define US_TO_CYC(us) (((us) * `CLK_FREQ_KHZ + 999) / 1000)

// ----------------------------------------
// Port geometry and reset values
// ----------------------------------------
`define NUM_DS 4
`define EN_RST 4'h0
`define USC_RST 8'h00
`define CNT_ZERO 24'h000000
`define CNT_ONE 24'h000001

`endif

/* hub_wake_pkg.sv */
// Types shared by the hub global-resume and wake logic
package hub_wake_pkg;
    // Top-level sequencing of global suspend and resume
    typedef enum logic [1:0] {ST_RUN, ST_SUSP, ST_RESUME, ST_FW_WAKE} wake_state_t;

    // Synchronised downstream line levels, one bit per port
    typedef struct packed {
        logic [3:0] dp;
        logic [3:0] dm;
    } ds_lines_t;

    // Downstream drive, one bit per port
    typedef struct packed {
        logic [3:0] dp;
        logic [3:0] dm;
        logic [3:0] oe;
    } ds_drive_t;

    // Upstream port status and control
    typedef struct packed {
        logic [3:0] rsvd;
        logic hw_k;
        logic host_k;
        logic resuming;
        logic suspended;
    } usc_t;
endpackage : hub_wake_pkg

/* wake_timer.sv */
// Minimum wake delay counter that holds the processor off after clocks restart
`timescale 1ns/1ps
`default_nettype none
`include "hub_wake_params.svh"

module wake_timer
    import hub_wake_pkg::*;
#(
    parameter logic [`CNT_W-1:0] CYCLES = 24'(`US_TO_CYC(`WAKE_DELAY_US))
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Control
    input wire logic start,
    output logic busy_r
);
    logic [`CNT_W-1:0] cnt_r;
    logic [`CNT_W-1:0] cnt_nxt;
    logic busy_nxt;

    // Count down from the full delay; a restart reloads it
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        if (start) begin
            cnt_nxt = CYCLES;
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            cnt_nxt = cnt_r - `CNT_ONE;
            busy_nxt = (cnt_r != `CNT_ONE);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= `CNT_ZERO;
            busy_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end

    // Hold lasts exactly the configured count once started
    busy_len_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (busy_r && !start && cnt_r > `CNT_ONE) |=> busy_r)
        else $error("wake hold ended early");
    busy_end_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (busy_r && !start && cnt_r == `CNT_ONE) |=> !busy_r)
        else $error("wake hold overran count");
endmodule : wake_timer
`default_nettype wire

/* hub_global_resume_wake.sv */
// Global resume and wake sequencing for a full-speed hub controller
// ----------------------------------------
// Overview of operation
// - Host resume seen during global suspend repeats its K to enabled ports and raises irq; no K is driven upstream.
// - A detected resume leaves suspend and restarts the internal clocks.
// - Processor stays held after restart until a counter has run for at least 1 ms.
// - Global resume and its repeated K end once the host stops driving K and any hardware upstream K count has run out.
// - An enabled port seeing SE0 during resume loses enable but keeps connect.
// - Any allowed downstream port change while suspended wakes the device.
// - With remote wakeup set, hardware drives upstream resume on downstream port wake events, not on host resume.
// - The upstream status and control register clears to zero on every reset.
// - Remote wakeup gates hardware upstream resume for connect or disconnect changes.
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "hub_wake_params.svh"

module hub_global_resume_wake
    import hub_wake_pkg::*;
#(
    parameter logic [`CNT_W-1:0] WAKE_CYCLES = 24'(`US_TO_CYC(`WAKE_DELAY_US)),
    parameter logic [`CNT_W-1:0] HW_K_CYCLES = 24'(`US_TO_CYC(`HW_K_DRIVE_US))
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Upstream port pins
    input wire logic up_dp_i,
    input wire logic up_dm_i,
    output logic up_dp_o,
    output logic up_dm_o,
    output logic up_oe,
    // Downstream port pins
    input wire ds_lines_t ds_i,
    output ds_drive_t ds_o,
    // Firmware control
    input wire logic suspend_req,
    input wire logic remote_wake_en,
    input wire logic usb_bus_rst,
    input wire logic en_wr,
    input wire logic [3:0] en_wdata,
    input wire logic [3:0] port_ls,
    input wire logic [3:0] port_conn,
    // Status to firmware
    output logic [3:0] port_en_r,
    output logic hub_irq_r,
    output logic clk_run_r,
    output logic cpu_hold_r,
    output usc_t usc_r
);
    // ----------------------------------------
    // Line decode
    // ----------------------------------------
    // K is D- high for full speed and D+ high for low speed
    function automatic logic line_k(input logic dp, input logic dm, input logic ls);
        line_k = ls ? (dp && !dm) : (!dp && dm);
    endfunction : line_k

    logic [1:0] up_s1_r;
    logic [1:0] up_s2_r;
    ds_lines_t ds_s1_r;
    ds_lines_t ds_s2_r;
    logic [3:0] conn_d_r;

    // Pins pass two flops before any decode
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            up_s1_r <= 2'h0;
            up_s2_r <= 2'h0;
            ds_s1_r <= '0;
            ds_s2_r <= '0;
            conn_d_r <= `EN_RST;
        end else begin
            up_s1_r <= {up_dp_i, up_dm_i};
            up_s2_r <= up_s1_r;
            ds_s1_r <= ds_i;
            ds_s2_r <= ds_s1_r;
            conn_d_r <= port_conn;
        end
    end

    logic host_k;
    logic [3:0] ds_k;
    logic [3:0] ds_se0;
    logic [3:0] conn_chg;

    assign host_k = line_k(up_s2_r[1], up_s2_r[0], 1'b0);
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_DS; gi++) begin : g_port
            assign ds_k[gi] = line_k(ds_s2_r.dp[gi], ds_s2_r.dm[gi], port_ls[gi]);
            assign ds_se0[gi] = !ds_s2_r.dp[gi] && !ds_s2_r.dm[gi];
            assign conn_chg[gi] = port_conn[gi] ^ conn_d_r[gi];
        end
    endgenerate

    logic port_evt;
    logic wake_evt;
    // A K from an enabled port, or any connect change even on a disabled port
    assign port_evt = |(ds_k & port_en_r) || |conn_chg;
    assign wake_evt = host_k || port_evt;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    wake_state_t state_r;
    wake_state_t state_nxt;
    logic [`CNT_W-1:0] hwk_r;
    logic [`CNT_W-1:0] hwk_nxt;
    logic [3:0] en_nxt;
    logic irq_nxt;
    logic clk_nxt;
    logic timer_start;
    logic timer_busy;
    logic hold_nxt;
    logic up_oe_nxt;
    ds_drive_t ds_nxt;
    usc_t usc_nxt;

    always_comb begin
        state_nxt = state_r;
        hwk_nxt = hwk_r;
        en_nxt = en_wr ? en_wdata : port_en_r;
        irq_nxt = 1'b0;
        timer_start = 1'b0;
        case (state_r)
            ST_RUN: begin
                if (suspend_req) begin
                    state_nxt = ST_SUSP;
                end
            end
            ST_SUSP: begin
                if (wake_evt) begin
                    irq_nxt = 1'b1;
                    timer_start = 1'b1;
                    if (host_k) begin
                        state_nxt = ST_RESUME;
                    end else if (remote_wake_en) begin
                        state_nxt = ST_RESUME;
                        hwk_nxt = HW_K_CYCLES;
                    end else begin
                        state_nxt = ST_FW_WAKE;
                    end
                end
            end
            ST_RESUME: begin
                if (hwk_r != `CNT_ZERO) begin
                    hwk_nxt = hwk_r - `CNT_ONE;
                end
                // SE0 drops enable; connect status is left alone
                en_nxt = en_nxt & ~(ds_se0 & port_en_r);
                if (!host_k && hwk_r == `CNT_ZERO) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_FW_WAKE: begin
                // Firmware times its own signalling, nothing driven here
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
        if (usb_bus_rst) begin
            en_nxt = `EN_RST;
        end
    end

    // Outputs derive from next state so every pin is a flop
    always_comb begin
        clk_nxt = (state_nxt != ST_SUSP);
        hold_nxt = timer_start || (timer_busy && state_r != ST_SUSP);
        up_oe_nxt = (state_nxt == ST_RESUME) && (hwk_nxt != `CNT_ZERO);
        ds_nxt.oe = (state_nxt == ST_RESUME) ? en_nxt : `EN_RST;
        ds_nxt.dp = ds_nxt.oe & port_ls;
        ds_nxt.dm = ds_nxt.oe & ~port_ls;
        usc_nxt = '0;
        usc_nxt.suspended = (state_nxt == ST_SUSP);
        usc_nxt.resuming = (state_nxt == ST_RESUME);
        usc_nxt.host_k = host_k;
        usc_nxt.hw_k = up_oe_nxt;
        if (usb_bus_rst) begin
            usc_nxt = `USC_RST;
        end
    end

    wake_timer #(
        .CYCLES(WAKE_CYCLES)
    ) u_wake_timer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .start(timer_start),
        .busy_r(timer_busy)
    );

    // Clocks and CPU run from reset; suspend is entered by request only
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_RUN;
            hwk_r <= `CNT_ZERO;
            port_en_r <= `EN_RST;
            hub_irq_r <= 1'b0;
            clk_run_r <= 1'b1;
            cpu_hold_r <= 1'b0;
            up_oe <= 1'b0;
            up_dp_o <= 1'b0;
            up_dm_o <= 1'b0;
            ds_o <= '0;
            usc_r <= `USC_RST;
        end else begin
            state_r <= state_nxt;
            hwk_r <= hwk_nxt;
            port_en_r <= en_nxt;
            hub_irq_r <= irq_nxt;
            clk_run_r <= clk_nxt;
            cpu_hold_r <= hold_nxt;
            up_oe <= up_oe_nxt;
            up_dp_o <= 1'b0;
            up_dm_o <= up_oe_nxt;
            ds_o <= ds_nxt;
            usc_r <= usc_nxt;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence host_resume_s;
        state_r == ST_SUSP && host_k;
    endsequence
    sequence port_wake_s;
        state_r == ST_SUSP && !host_k && port_evt;
    endsequence

    host_wake_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        host_resume_s |=> (state_r == ST_RESUME) && hub_irq_r && clk_run_r)
        else $error("host resume not taken");
    ds_repeat_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ds_o.oe == ((state_r == ST_RESUME) ? port_en_r : 4'h0))
        else $error("downstream K repeat mismatch");
    clk_restart_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (host_resume_s or port_wake_s) |=> clk_run_r ##0 $rose(cpu_hold_r))
        else $error("wake did not restart clocks");
    hold_span_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(cpu_hold_r) |-> cpu_hold_r [*8])
        else $error("processor released too soon");
    resume_end_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_r == ST_RESUME && !host_k && hwk_r == 24'h0) |=> state_r == ST_RUN)
        else $error("resume did not end");
    se0_drop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_r == ST_RESUME) |=> (port_en_r & $past(ds_se0 & port_en_r)) == 4'h0)
        else $error("SE0 port kept enable");
    port_wake_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        port_wake_s |=> state_r != ST_SUSP && hub_irq_r)
        else $error("port change did not wake");
    remote_on_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (port_wake_s and remote_wake_en) |=> up_oe && up_dm_o && !up_dp_o)
        else $error("hardware resume K missing");
    remote_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (port_wake_s and !remote_wake_en) |=> !up_oe [*2])
        else $error("hardware K without remote wakeup");
    usc_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        usb_bus_rst |=> usc_r == 8'h00)
        else $error("status register not cleared");
endmodule : hub_global_resume_wake
`default_nettype wire

/* host_model.sv */
// Upstream host model driving the hub's upstream line pair
`timescale 1ns/1ps
`default_nettype none

module host_model (
    // Clock
    input wire logic ref_clk,
    // Requests from the bench
    input wire logic k_req,
    input wire logic slow,
    // Upstream line levels seen by the hub
    output logic dp,
    output logic dm
);
    logic [1:0] dly_r;

    // Slow host starts its K three cycles late, to stress the sync path
    always_ff @(posedge ref_clk) begin
        dly_r <= (k_req && dly_r != 2'h3) ? dly_r + 2'h1 : (k_req ? dly_r : 2'h0);
    end

    // Idle is J because the pull-up sits on D+; K is dropped at once when done
    assign dp = !(k_req && (!slow || dly_r == 2'h3));
    assign dm = !dp;
endmodule : host_model

`default_nettype wire

/* testbench.sv */
// Self-checking bench for global resume and wake sequencing
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import hub_wake_pkg::*;
    localparam logic [23:0] WAKE_N = 24'h000014;
    localparam logic [23:0] HWK_N = 24'h00001e;
    logic ref_clk, sys_rst, up_dp_i, up_dm_i, up_dp_o, up_dm_o, up_oe;
    logic suspend_req, remote_wake_en, usb_bus_rst, en_wr, hub_irq_r, clk_run_r, cpu_hold_r;
    logic k_req, slow;
    logic [3:0] en_wdata, port_ls, port_conn, port_en_r, exp_en, exp_oe;
    ds_lines_t ds_i;
    ds_drive_t ds_o;
    usc_t usc_r;
    int n_errors, total_checks, n, m, oe_run, oe_len;
    logic [31:0] seed;

    hub_global_resume_wake #(.WAKE_CYCLES(WAKE_N), .HW_K_CYCLES(HWK_N)) u_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .up_dp_i(up_dp_i), .up_dm_i(up_dm_i),
        .up_dp_o(up_dp_o), .up_dm_o(up_dm_o), .up_oe(up_oe), .ds_i(ds_i), .ds_o(ds_o),
        .suspend_req(suspend_req), .remote_wake_en(remote_wake_en),
        .usb_bus_rst(usb_bus_rst), .en_wr(en_wr), .en_wdata(en_wdata), .port_ls(port_ls),
        .port_conn(port_conn), .port_en_r(port_en_r), .hub_irq_r(hub_irq_r),
        .clk_run_r(clk_run_r), .cpu_hold_r(cpu_hold_r), .usc_r(usc_r));

    host_model u_host (.ref_clk(ref_clk), .k_req(k_req), .slow(slow), .dp(up_dp_i),
        .dm(up_dm_i));

    // ----------------------------------------
    // Clock and helpers
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic conclude();
        $display("Counts: %0d checks, %0d mismatches", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude

    // Idle J per port: low-speed idles with D- high
    function automatic ds_lines_t idle_j(input logic [3:0] ls);
        return '{dp: ~ls, dm: ls};
    endfunction : idle_j

    // Status just after a wake: resume state except modes 2 and 3, host K seen in modes 0 and 4, hardware K driven in mode 1
    function automatic usc_t exp_usc(input int md);
        exp_usc = '0;
        exp_usc.resuming = (md != 2 && md != 3);
        exp_usc.host_k = (md == 0 || md == 4);
        exp_usc.hw_k = (md == 1);
    endfunction : exp_usc

    // Upstream K length and polarity, watched mid-cycle so the sample never races the edge
    always @(negedge ref_clk) begin
        if (up_oe === 1'b1) begin
            oe_run = oe_run + 1;
            check("up_k", 32'h1, {up_dp_o, up_dm_o});
        end else if (oe_run != 0) begin
            oe_len = oe_run;
            oe_run = 0;
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'h898a;
        {n_errors, total_checks, oe_run, oe_len} = '0;
        {suspend_req, remote_wake_en, usb_bus_rst, en_wr, k_req, slow} = '0;
        en_wdata = 4'h0;
        port_ls = 4'($random(seed));
        port_conn = 4'($random(seed));
        ds_i = idle_j(port_ls);
        sys_rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        tick(1);
        check("usc_rst", 32'h0, usc_r);
        // Port changes while running must not wake anything
        for (n = 0; n < 8; n++) begin
            port_conn <= 4'($random(seed));
            tick(1);
            check("irq_run", 32'h0, hub_irq_r);
        end
        $display("Run-time change test done, %0d mismatches so far", n_errors);
        exp_en = 4'($random(seed)) | 4'h1;
        en_wdata <= exp_en;
        en_wr <= 1'b1;
        tick(1);
        en_wr <= 1'b0;
        tick(1);
        // Modes: host K, connect change (remote wake on, off), port K, slow host K with SE0
        for (m = 0; m < 5; m++) begin
            oe_len = 0;
            remote_wake_en <= (m == 1);
            suspend_req <= 1'b1;
            tick(1);
            suspend_req <= 1'b0;
            tick(2);
            check("clk_stop", 32'h0, clk_run_r);
            if (m == 0 || m == 4) begin
                k_req <= 1'b1;
                slow <= (m == 4);
            end else if (m == 3) begin
                // K on enabled port 0, polarity set by its speed
                ds_i.dp[0] <= port_ls[0];
                ds_i.dm[0] <= !port_ls[0];
            end else begin
                port_conn <= port_conn ^ (4'h1 << ($random(seed) & 3));
            end
            n = 0;
            while (hub_irq_r !== 1'b1 && n < 50) begin
                tick(1);
                n++;
            end
            if (n == 50) begin
                n_errors++;
                conclude();
            end
            exp_oe = (m == 2 || m == 3) ? 4'h0 : exp_en;
            check("clk_run", 32'h1, clk_run_r);
            check("usc_wake", exp_usc(m), usc_r);
            check("ds_oe", exp_oe, ds_o.oe);
            check("ds_k_dp", exp_oe & port_ls, ds_o.dp);
            check("ds_k_dm", exp_oe & ~port_ls, ds_o.dm);
            n = 0;
            while (cpu_hold_r === 1'b1 && n < 100) begin
                n++;
                tick(1);
            end
            check("hold_len", WAKE_N + 1, n);
            if (n == 100) conclude();
            // Acting as firmware: no port is selectively suspended, nothing to clear
            if (m == 4) begin
                ds_i.dp[0] <= 1'b0;
                ds_i.dm[0] <= 1'b0;
                tick(4);
                exp_en = exp_en & 4'he;
                check("se0_en", exp_en, port_en_r);
            end
            k_req <= 1'b0;
            ds_i <= idle_j(port_ls);
            tick(40);
            check("ds_idle", 32'h0, ds_o.oe);
            check("up_len", (m == 1) ? HWK_N : 24'h0, oe_len);
            $display("Wake mode %0d done, %0d mismatches so far", m, n_errors);
        end
        // Bus reset taken while suspended, so the status register is not already zero
        suspend_req <= 1'b1;
        tick(1);
        suspend_req <= 1'b0;
        en_wdata <= 4'hf;
        en_wr <= 1'b1;
        tick(1);
        en_wr <= 1'b0;
        check("usc_susp", 32'h1, usc_r);
        check("en_write", 32'hf, port_en_r);
        usb_bus_rst <= 1'b1;
        tick(1);
        usb_bus_rst <= 1'b0;
        check("busrst_en", 32'h0, port_en_r);
        check("busrst_usc", 32'h0, usc_r);
        $display("Bus reset test done");
        // Device reset in mid-run, again from suspend
        tick(1);
        check("usc_back", 32'h1, usc_r);
        sys_rst <= 1'b1;
        tick(1);
        check("rst_usc", 32'h0, usc_r);
        sys_rst <= 1'b0;
        tick(2);
        check("rst_clk", 32'h1, clk_run_r);
        check("rst_state", 32'h0, usc_r);
        $display("Device reset test done");
        conclude();
    end
endmodule : testbench

`default_nettype wire
